// ==== pkg/bss_pkg.sv ====
package bss_pkg;

  // ---------------------------------------------------------------
  // strap encodings
  // ---------------------------------------------------------------
  localparam logic STRAP_TEST_BSCAN    = 1'b1;
  localparam logic STRAP_VOLT_3V3      = 1'b1;
  localparam logic STRAP_RECOVERY      = 1'b0;
  localparam logic STRAP_CMP_ENABLE    = 1'b1;
  localparam logic STRAP_BOOT_SHARED   = 1'b1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_STRAP_TEST      = 1'b0;
  localparam logic RST_STRAP_VOLT      = 1'b1;
  localparam logic RST_STRAP_RECOVERY  = 1'b1;
  localparam logic RST_STRAP_CMP       = 1'b0;
  localparam logic RST_STRAP_BOOT      = 1'b1;
  localparam int   BGPO_COUNT          = 2;

  typedef enum logic [1:0] {
    BSS_BOOT_SHARED,
    BSS_BOOT_ESPI,
    BSS_BOOT_RECOVERY
  } bss_boot_type;

  typedef struct packed {
    logic test_select;
    logic flash_voltage;
    logic recovery_boot;
    logic comparator_enable;
    logic boot_source;
  } boot_source_strap_type;

  localparam boot_source_strap_type STRAP_RESET = '{
    test_select:       RST_STRAP_TEST,
    flash_voltage:     RST_STRAP_VOLT,
    recovery_boot:     RST_STRAP_RECOVERY,
    comparator_enable: RST_STRAP_CMP,
    boot_source:       RST_STRAP_BOOT
  };

endpackage : bss_pkg

// ==== logic/boot_source_strap_latch.sv ====
`timescale 1ns/10ps
module boot_source_strap_latch
  import bss_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire boot_source_strap_type pins,
  output boot_source_strap_type      captured,
  output logic               valid
);

  // ---------------------------------------------------------------
  // one-shot capture at first edge after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      captured <= STRAP_RESET;
      valid    <= 1'b0;
    end else if (!valid) begin
      captured <= pins;
      valid    <= 1'b1;
    end
  end

endmodule : boot_source_strap_latch

// ==== logic/bss_boot_strap_sampling.sv ====
`timescale 1ns/10ps
// Function
// - test strap 1 routes debug port to boundary scan, 0 to cpu debug
// - voltage strap 1 selects 3.3V flash signalling, 0 selects 1.8V
// - recovery strap 0 boots recovery flash on private pins
// - comparator strap honoured only if otp enables; 1 enables comparator
// - boot-source strap 1 boots shared spi, 0 boots espi flash channel
// - espi boot: shared select pin becomes resume reset, driven high
// - espi boot: flash data pin becomes deep-sleep power good, high
// - spi flash load only when shared select pin sampled high
// - debug controller active: test strap pin only an output
// - test strap pin input only when no debug controller needed
// - battery outputs zero at battery power, programmable, retained
// - other unprogrammed pins stay tristated until firmware sets them
// - battery control output combines battery inputs and ec setting, unless ec override selects the ec setting alone
module bss_boot_strap_sampling
  import bss_pkg::*;
#(
  parameter int BGPO_W = BGPO_COUNT,
  parameter int VCI_W  = 4
)(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              battery_por_n,
  input  wire logic              test_select_strap_pin,
  input  wire logic              voltage_strap_pin,
  input  wire logic              recovery_strap_pin,
  input  wire logic              comparator_strap_pin,
  input  wire logic              boot_source_pin,
  input  wire logic              otp_comparator_strap_en,
  input  wire logic              debug_controller_active,
  input  wire logic              boot_resume_reset_set,
  input  wire logic              boot_power_good_set,
  input  wire logic              fw_test_pin_drive,
  input  wire logic              fw_test_pin_value,
  input  wire logic              fw_gpio_cfg_valid,
  input  wire logic              fw_gpio_out,
  input  wire logic              fw_gpio_oe_n,
  input  wire logic              bgpo_write,
  input  wire logic [BGPO_W-1:0] bgpo_wdata,
  input  wire logic [VCI_W-1:0]  battery_inputs_n,
  input  wire logic              ec_vci_setting,
  input  wire logic              ec_vci_override,
  output logic                   debug_to_boundary_scan,
  output logic                   flash_io_3v3,
  output logic                   recovery_boot,
  output logic                   comparator0_enable,
  output logic                   boot_from_shared_spi,
  output logic                   spi_flash_load_ok,
  output bss_boot_type           boot_mode,
  output logic                   resume_reset_out_n,
  output logic                   resume_reset_oe_n,
  output logic                   deep_sleep_power_good,
  output logic                   deep_sleep_power_good_oe_n,
  output logic                   test_select_out,
  output logic                   test_select_oe_n,
  output logic                   gpio_out,
  output logic                   gpio_oe_n,
  output logic [BGPO_W-1:0]      battery_gp_output,
  output logic                   battery_control_output,
  output logic                   straps_valid
);

  // ---------------------------------------------------------------
  // strap decode helpers
  // ---------------------------------------------------------------
  function automatic logic strap_recovery(input boot_source_strap_type s);
    return s.recovery_boot == STRAP_RECOVERY;
  endfunction : strap_recovery

  function automatic logic strap_shared(input boot_source_strap_type s);
    return s.boot_source == STRAP_BOOT_SHARED;
  endfunction : strap_shared

  // recovery strap overrides the boot source
  function automatic bss_boot_type strap_mode(input boot_source_strap_type s);
    bss_boot_type mode;
    mode = BSS_BOOT_SHARED;
    case ({strap_recovery(s), strap_shared(s)})
      2'b10, 2'b11: mode = BSS_BOOT_RECOVERY;
      2'b01:        mode = BSS_BOOT_SHARED;
      2'b00:        mode = BSS_BOOT_ESPI;
      default:      mode = BSS_BOOT_SHARED;
    endcase
    return mode;
  endfunction : strap_mode

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  boot_source_strap_type pins;
  boot_source_strap_type cap;
  logic          cap_valid;
  logic          cap_valid_q;

  assign pins = '{
    test_select:       test_select_strap_pin,
    flash_voltage:     voltage_strap_pin,
    recovery_boot:     recovery_strap_pin,
    comparator_enable: comparator_strap_pin,
    boot_source:       boot_source_pin
  };

  boot_source_strap_latch u_latch (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .pins     (pins),
    .captured (cap),
    .valid    (cap_valid)
  );

  // delayed flag, pins turn only after the decode settles
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cap_valid_q <= 1'b0;
    end else begin
      cap_valid_q <= cap_valid;
    end
  end

  // ---------------------------------------------------------------
  // decoded configuration, one register per output
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      straps_valid <= 1'b0;
    end else begin
      straps_valid <= cap_valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      debug_to_boundary_scan <= 1'b0;
    end else begin
      debug_to_boundary_scan <=
          (cap.test_select == STRAP_TEST_BSCAN);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flash_io_3v3 <= RST_STRAP_VOLT;
    end else begin
      flash_io_3v3 <= (cap.flash_voltage == STRAP_VOLT_3V3);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      recovery_boot <= 1'b0;
    end else begin
      recovery_boot <= cap_valid && strap_recovery(cap);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      comparator0_enable <= 1'b0;
    end else begin
      comparator0_enable <= otp_comparator_strap_en
          && (cap.comparator_enable == STRAP_CMP_ENABLE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      boot_from_shared_spi <= RST_STRAP_BOOT;
    end else begin
      boot_from_shared_spi <= strap_shared(cap);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      spi_flash_load_ok <= 1'b0;
    end else begin
      spi_flash_load_ok <= cap_valid && strap_shared(cap)
          && !strap_recovery(cap);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      boot_mode <= BSS_BOOT_SHARED;
    end else begin
      boot_mode <= strap_mode(cap);
    end
  end

  // ---------------------------------------------------------------
  // espi boot handshake outputs
  // ---------------------------------------------------------------
  // pins stay released until the boot source is known
  logic espi_boot;
  assign espi_boot = cap_valid_q && (strap_mode(cap) == BSS_BOOT_ESPI);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      resume_reset_oe_n <= 1'b1;
    end else begin
      resume_reset_oe_n <= !espi_boot;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      resume_reset_out_n <= 1'b0;
    end else if (espi_boot && boot_resume_reset_set) begin
      resume_reset_out_n <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      deep_sleep_power_good_oe_n <= 1'b1;
    end else begin
      deep_sleep_power_good_oe_n <= !espi_boot;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      deep_sleep_power_good <= 1'b0;
    end else if (espi_boot && boot_power_good_set) begin
      deep_sleep_power_good <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // test select strap pin direction
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      test_select_out <= 1'b0;
    end else begin
      test_select_out <= fw_test_pin_value;
    end
  end

  // drive only once straps are taken, never during capture
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      test_select_oe_n <= 1'b1;
    end else if (debug_controller_active) begin
      test_select_oe_n <= !cap_valid_q;
    end else begin
      test_select_oe_n <= !(cap_valid_q && fw_test_pin_drive);
    end
  end

  // ---------------------------------------------------------------
  // generic pins tristate until programmed
  // ---------------------------------------------------------------
  // sticky until system reset
  logic gpio_programmed;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gpio_programmed <= 1'b0;
    end else if (fw_gpio_cfg_valid) begin
      gpio_programmed <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gpio_out <= 1'b0;
    end else begin
      gpio_out <= fw_gpio_out;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gpio_oe_n <= 1'b1;
    end else begin
      gpio_oe_n <= !(gpio_programmed && !fw_gpio_oe_n);
    end
  end

  // ---------------------------------------------------------------
  // battery domain, survives standby rail cycles
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    // battery power-on only, system reset leaves it
    if (!battery_por_n) begin
      battery_gp_output <= '0;
    end else if (bgpo_write) begin
      battery_gp_output <= bgpo_wdata;
    end
  end

  // ---------------------------------------------------------------
  // battery control output
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!battery_por_n) begin
      battery_control_output <= 1'b0;
    end else begin
      battery_control_output <= ec_vci_override ? ec_vci_setting
          : (ec_vci_setting || !(&battery_inputs_n));
    end
  end

endmodule : bss_boot_strap_sampling

// ==== dv/bss_asserts.sv ====
`timescale 1ns/10ps
module bss_asserts
  import bss_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         resetn,
  input wire logic         fw_gpio_cfg_valid,
  input wire logic         debug_controller_active,
  input wire logic         fw_test_pin_drive,
  input wire logic         recovery_boot,
  input wire logic         boot_from_shared_spi,
  input wire logic         spi_flash_load_ok,
  input wire bss_boot_type boot_mode,
  input wire logic         resume_reset_oe_n,
  input wire logic         test_select_oe_n,
  input wire logic         gpio_oe_n,
  input wire logic         straps_valid
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // firmware has programmed the generic pin since reset
  logic cfg_seen;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg_seen <= 1'b0;
    end else if (fw_gpio_cfg_valid) begin
      cfg_seen <= 1'b1;
    end
  end
  AST_VALID: assert property (
    $rose(resetn) |-> ##[1:2] straps_valid) else $error("valid late");
  AST_HOLD: assert property (
    straps_valid && $past(straps_valid) |->
      $stable({boot_mode, recovery_boot, spi_flash_load_ok}))
    else $error("straps changed");
  AST_MODE: assert property (
    straps_valid |-> boot_mode == (recovery_boot ? BSS_BOOT_RECOVERY :
      boot_from_shared_spi ? BSS_BOOT_SHARED : BSS_BOOT_ESPI))
    else $error("boot mode wrong");
  AST_LOAD: assert property (
    boot_mode != BSS_BOOT_SHARED |-> !spi_flash_load_ok)
    else $error("flash load outside shared boot");
  AST_RROE: assert property (
    !resume_reset_oe_n |-> straps_valid && boot_mode == BSS_BOOT_ESPI)
    else $error("resume reset driven outside espi");
  AST_DBG: assert property (
    debug_controller_active && straps_valid |=> !test_select_oe_n)
    else $error("test pin not output in debug");
  AST_TSIN: assert property (
    !debug_controller_active && !fw_test_pin_drive |=> test_select_oe_n)
    else $error("test pin driven as input");
  AST_GPIO: assert property (
    !cfg_seen |-> gpio_oe_n)
    else $error("gpio driven before programming");
  COV_ESPI: cover property (straps_valid && boot_mode == BSS_BOOT_ESPI);
  COV_REC: cover property (straps_valid && recovery_boot);
  COV_DBG: cover property (debug_controller_active && !test_select_oe_n);
endmodule : bss_asserts

bind bss_boot_strap_sampling bss_asserts bss_asserts_inst (
  .sys_clk                 (sys_clk),
  .resetn                  (resetn),
  .fw_gpio_cfg_valid       (fw_gpio_cfg_valid),
  .debug_controller_active (debug_controller_active),
  .fw_test_pin_drive       (fw_test_pin_drive),
  .recovery_boot           (recovery_boot),
  .boot_from_shared_spi    (boot_from_shared_spi),
  .spi_flash_load_ok       (spi_flash_load_ok),
  .boot_mode               (boot_mode),
  .resume_reset_oe_n       (resume_reset_oe_n),
  .test_select_oe_n        (test_select_oe_n),
  .gpio_oe_n               (gpio_oe_n),
  .straps_valid            (straps_valid)
);

// ==== dv/bss_board.sv ====
`timescale 1ns/10ps
module bss_board
  import bss_pkg::*;
(
  input  wire logic [4:0] cfg,
  input  wire logic       wobble,
  output boot_source_strap_type   pins
);
  // straps reused as gpio once captured
  assign pins = wobble ? ~cfg : cfg;
endmodule : bss_board

// ==== dv/bss_boot_strap_sampling_tb_top.sv ====
`timescale 1ns/10ps
module bss_boot_strap_sampling_tb_top import bss_pkg::*;;
  logic sys_clk, resetn, battery_por_n, otp_comparator_strap_en, wobble;
  logic debug_controller_active, boot_resume_reset_set, boot_power_good_set;
  logic fw_test_pin_drive, fw_test_pin_value, fw_gpio_cfg_valid, bgpo_write;
  logic fw_gpio_out, fw_gpio_oe_n, ec_vci_setting, ec_vci_override, v;
  logic test_select_strap_pin, voltage_strap_pin, recovery_strap_pin;
  logic comparator_strap_pin, boot_source_pin, debug_to_boundary_scan;
  logic flash_io_3v3, recovery_boot, comparator0_enable, spi_flash_load_ok;
  logic boot_from_shared_spi, resume_reset_out_n, resume_reset_oe_n;
  logic deep_sleep_power_good, deep_sleep_power_good_oe_n, test_select_out;
  logic test_select_oe_n, gpio_out, gpio_oe_n, battery_control_output;
  logic straps_valid;
  logic [1:0] bgpo_wdata, battery_gp_output, bgpo_exp;
  logic [3:0] battery_inputs_n;
  logic [4:0] cfg;
  logic [31:0] seed, r;
  bss_boot_type boot_mode;
  boot_source_strap_type pins;
  int failures = 0, total_checks = 0, m;
  assign {test_select_strap_pin, voltage_strap_pin, recovery_strap_pin,
          comparator_strap_pin, boot_source_pin} = pins;
  bss_board bss_board_inst (
    .cfg    (cfg),
    .wobble (wobble),
    .pins   (pins)
  );
  bss_boot_strap_sampling bss_boot_strap_sampling_inst (
    .sys_clk                    (sys_clk),
    .resetn                     (resetn),
    .battery_por_n              (battery_por_n),
    .test_select_strap_pin      (test_select_strap_pin),
    .voltage_strap_pin          (voltage_strap_pin),
    .recovery_strap_pin         (recovery_strap_pin),
    .comparator_strap_pin       (comparator_strap_pin),
    .boot_source_pin            (boot_source_pin),
    .otp_comparator_strap_en    (otp_comparator_strap_en),
    .debug_controller_active    (debug_controller_active),
    .boot_resume_reset_set      (boot_resume_reset_set),
    .boot_power_good_set        (boot_power_good_set),
    .fw_test_pin_drive          (fw_test_pin_drive),
    .fw_test_pin_value          (fw_test_pin_value),
    .fw_gpio_cfg_valid          (fw_gpio_cfg_valid),
    .fw_gpio_out                (fw_gpio_out),
    .fw_gpio_oe_n               (fw_gpio_oe_n),
    .bgpo_write                 (bgpo_write),
    .bgpo_wdata                 (bgpo_wdata),
    .battery_inputs_n           (battery_inputs_n),
    .ec_vci_setting             (ec_vci_setting),
    .ec_vci_override            (ec_vci_override),
    .debug_to_boundary_scan     (debug_to_boundary_scan),
    .flash_io_3v3               (flash_io_3v3),
    .recovery_boot              (recovery_boot),
    .comparator0_enable         (comparator0_enable),
    .boot_from_shared_spi       (boot_from_shared_spi),
    .spi_flash_load_ok          (spi_flash_load_ok),
    .boot_mode                  (boot_mode),
    .resume_reset_out_n         (resume_reset_out_n),
    .resume_reset_oe_n          (resume_reset_oe_n),
    .deep_sleep_power_good      (deep_sleep_power_good),
    .deep_sleep_power_good_oe_n (deep_sleep_power_good_oe_n),
    .test_select_out            (test_select_out),
    .test_select_oe_n           (test_select_oe_n),
    .gpio_out                   (gpio_out),
    .gpio_oe_n                  (gpio_oe_n),
    .battery_gp_output          (battery_gp_output),
    .battery_control_output     (battery_control_output),
    .straps_valid               (straps_valid)
  );
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic check(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic boot();
    resetn = 1'b0;
    wobble = 1'b0;
    tick(5);
    resetn = 1'b1;
    tick(3);
  endtask : boot
  initial begin
    #500_000;
    failures++;
    results();
  end
  initial begin
    {resetn, battery_por_n, otp_comparator_strap_en, debug_controller_active,
     boot_resume_reset_set, boot_power_good_set, fw_test_pin_drive, wobble,
     fw_test_pin_value, fw_gpio_cfg_valid, fw_gpio_out, bgpo_write,
     ec_vci_setting, ec_vci_override, bgpo_wdata, bgpo_exp} = '0;
    {fw_gpio_oe_n, battery_inputs_n, cfg} = '1;
    seed = 32'h000141c1;
    boot();
    check("bgpo por", battery_gp_output, 8'h00);
    battery_por_n = 1'b1;
    for (int i = 0; i < 32; i++) begin
      r = xs();
      cfg = i[4:0];
      otp_comparator_strap_en = r[0];
      boot();
      check("keep", battery_gp_output, bgpo_exp);
      wobble = 1'b1;
      debug_controller_active = r[1];
      {fw_test_pin_drive, fw_test_pin_value} = r[3:2];
      {boot_resume_reset_set, boot_power_good_set, bgpo_write} = 3'h7;
      bgpo_wdata = r[5:4];
      battery_inputs_n = r[9:6];
      {ec_vci_setting, ec_vci_override} = r[11:10];
      tick(1);
      {boot_resume_reset_set, boot_power_good_set, bgpo_write} = 3'h0;
      tick(2);
      m = cfg[2] ? !cfg[0] : 2;
      v = r[10] ? r[11] : r[11] | ~&r[9:6];
      bgpo_exp = r[5:4];
      check("scan", debug_to_boundary_scan, cfg[4]);
      check("v33", flash_io_3v3, cfg[3]);
      check("rec", recovery_boot, !cfg[2]);
      check("cmp", comparator0_enable, cfg[1] & r[0]);
      check("mode", boot_mode, m[7:0]);
      check("load", spi_flash_load_ok, m == 0);
      check("rr oe", resume_reset_oe_n, m != 1);
      check("pg oe", deep_sleep_power_good_oe_n, m != 1);
      check("rr", resume_reset_out_n, m == 1);
      check("pg", deep_sleep_power_good, m == 1);
      check("valid", straps_valid, 1'b1);
      check("shared", boot_from_shared_spi, cfg[0]);
      check("ts oe", test_select_oe_n, !(r[1] | r[3]));
      check("ts out", test_select_out, r[2]);
      check("gpio", gpio_oe_n, 1'b1);
      check("gpio lo", gpio_out, 1'b0);
      check("bgpo", battery_gp_output, bgpo_exp);
      check("vci", battery_control_output, v);
    end
    {fw_gpio_cfg_valid, fw_gpio_out, fw_gpio_oe_n} = 3'h6;
    tick(1);
    fw_gpio_cfg_valid = 1'b0;
    tick(1);
    check("gpio oe", gpio_oe_n, 1'b0);
    check("gpio out", gpio_out, 1'b1);
    results();
  end
endmodule : bss_boot_strap_sampling_tb_top
